/* hdl/pcso_setpoint_outputs.sv */
// setpoint compare, overflow flag and process-image access of the position counter
`timescale 1ns/100ps
`default_nettype none
`include "pcso_defines.svh"
module pcso_setpoint_outputs (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        enable_pin_i,
  input  wire logic        count_up_i,
  input  wire logic        count_down_i,
  input  wire logic        sync_done_i,
  input  wire logic [1:0]  out_addr_i,
  input  wire logic [7:0]  out_data_i,
  input  wire logic        out_wr_i,
  input  wire logic [1:0]  in_addr_i,
  output logic      [7:0]  in_data_o,
  output logic             first_output_o,
  output logic             second_output_o
);

  // ***************************************************************
  // enable pin
  // ***************************************************************
  pcso_sync_if en_if ();

  pcso_enable_sync u_sync (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .enable_pin_i (enable_pin_i),
    .sync         (en_if)
  );

  // ***************************************************************
  // decoding helpers
  // ***************************************************************
  function automatic logic [7:0] pcso_byte_sel(input logic [15:0] w, input logic hi);
    pcso_byte_sel = hi ? w[15:8] : w[7:0];
  endfunction : pcso_byte_sel

  function automatic logic pcso_hit_ok(
    input logic synced, input logic ovf, input logic en,
    input logic [15:0] pos, input logic [15:0] sp);
    pcso_hit_ok = synced & ~ovf & en & (pos == sp);
  endfunction : pcso_hit_ok

  // ***************************************************************
  // counter state
  // ***************************************************************
  pcso_pkg::pcso_word_t position;
  pcso_pkg::pcso_word_t next_position;
  logic                 synced;
  logic                 next_synced;
  logic                 overflow;
  logic                 next_overflow;
  pcso_pkg::pcso_dir_e  dir;

  always_comb begin
    dir = pcso_pkg::PCSO_DIR_HOLD;
    if (count_up_i && !count_down_i) begin
      dir = pcso_pkg::PCSO_DIR_UP;
    end else if (count_down_i && !count_up_i) begin
      dir = pcso_pkg::PCSO_DIR_DOWN;
    end
  end

  always_comb begin
    next_position = position;
    next_synced   = synced;
    next_overflow = overflow;
    if (sync_done_i) begin
      next_position = `PCSO_POS_RESET;
      next_synced   = 1'b1;
      next_overflow = 1'b0;
    end else begin
      case (dir)
        pcso_pkg::PCSO_DIR_UP: begin
          next_position = position + 16'sh0001;
          if (position == 16'sh7FFF) begin
            next_overflow = 1'b1;
          end
        end
        pcso_pkg::PCSO_DIR_DOWN: begin
          next_position = position - 16'sh0001;
          if (position == 16'sh8000) begin
            next_overflow = 1'b1;
          end
        end
        default: begin
          next_position = position;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      position <= `PCSO_POS_RESET;
      synced   <= 1'b0;
      overflow <= 1'b0;
    end else begin
      position <= next_position;
      synced   <= next_synced;
      overflow <= next_overflow;
    end
  end

  // ***************************************************************
  // setpoints and switched outputs
  // ***************************************************************
  logic [1:0][15:0] sp_active;
  logic [1:0][15:0] next_sp_active;
  logic [1:0][15:0] sp_written;
  logic [1:0][15:0] next_sp_written;
  logic [1:0]       pending;
  logic [1:0]       next_pending;
  logic [1:0]       hit;
  logic [1:0]       next_hit;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sp
      logic wr_hi;
      logic wr_lo;
      logic wr_done;
      logic [15:0] wval;
      assign wr_hi   = out_wr_i && (out_addr_i == 2'(2 * g));
      assign wr_lo   = out_wr_i && (out_addr_i == 2'(2 * g + 1));
      assign wr_done = wr_lo;
      assign wval    = wr_hi ? {out_data_i, sp_written[g][7:0]}
                     : wr_lo ? {sp_written[g][15:8], out_data_i}
                     : sp_written[g];

      always_comb begin
        next_sp_written[g] = wval;
        next_sp_active[g]  = sp_active[g];
        next_pending[g]    = pending[g];
        next_hit[g]        = hit[g];
        if (wr_hi || wr_done) begin
          if (!hit[g]) begin
            next_sp_active[g] = wval;
            next_pending[g]   = 1'b0;
          end else begin
            next_pending[g]   = 1'b1;
          end
        end
        if (en_if.enable_rise && pending[g]) begin
          next_sp_active[g] = sp_written[g];
          next_pending[g]   = 1'b0;
        end
        if (en_if.enable_fall) begin
          next_hit[g] = 1'b0;
        end else if (pcso_hit_ok(synced, overflow, en_if.enable_level,
                                 position, sp_active[g])) begin
          next_hit[g] = 1'b1;
        end
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sp_active[g]  <= `PCSO_SP_RESET;
          sp_written[g] <= `PCSO_SP_RESET;
          pending[g]    <= 1'b0;
          hit[g]        <= 1'b0;
        end else begin
          sp_active[g]  <= next_sp_active[g];
          sp_written[g] <= next_sp_written[g];
          pending[g]    <= next_pending[g];
          hit[g]        <= next_hit[g];
        end
      end
    end
  endgenerate

  // ***************************************************************
  // input image and pins
  // ***************************************************************
  logic [7:0] diag;
  logic [7:0] next_in_data;

  always_comb begin
    diag = 8'h00;
    diag[`PCSO_DIAG_SYNC] = synced;
    diag[`PCSO_DIAG_HIT1] = hit[0];
    diag[`PCSO_DIAG_HIT2] = hit[1];
    diag[`PCSO_DIAG_OVF]  = overflow;
    case (in_addr_i)
      `PCSO_IN_DIAG:   next_in_data = diag;
      `PCSO_IN_POS_HI: next_in_data = pcso_byte_sel(position, 1'b1);
      `PCSO_IN_POS_LO: next_in_data = pcso_byte_sel(position, 1'b0);
      default:         next_in_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_data_o       <= 8'h00;
      first_output_o  <= 1'b0;
      second_output_o <= 1'b0;
    end else begin
      in_data_o       <= next_in_data;
      first_output_o  <= next_hit[0];
      second_output_o <= next_hit[1];
    end
  end

endmodule : pcso_setpoint_outputs
`default_nettype wire

/* hdl/pcso_defines.svh */
// constants of the setpoint-compare and overflow block
// Summary of operation
// - set output and reached flag stay set through reversal; only enable low clears them.
// - count leaving signed 16-bit range sets overflow flag, diagnostic bit 3.
// - while overflowed no output newly switches on; active outputs stay on.
// - overflow neither switches active outputs off nor clears sync bit 0.
// - controller re-references after overflow; sync completion clears overflow flag.
// - setpoint written while its reached flag is clear takes effect at once.
// - setpoint written while its reached flag is set waits for enable rising edge.
// - diagnostic bit 1 shows setpoint 1 reached, bit 2 setpoint 2 reached.
// - enable falling edge switches both outputs off and clears both reached flags.
// - after accepting pending setpoints, output switches on again at the new setpoint.
// - input bytes: 0 unused, 1 diagnostic, 2-3 position; output bytes hold setpoints.
// - output sets only when synced, no overflow, enable high, count equals setpoint.
// - position is reported as signed two's-complement 16-bit.
`ifndef PCSO_DEFINES_SVH
`define PCSO_DEFINES_SVH
`define PCSO_IN_UNUSED     2'h0
`define PCSO_IN_DIAG       2'h1
`define PCSO_IN_POS_HI     2'h2
`define PCSO_IN_POS_LO     2'h3
`define PCSO_OUT_SP1_HI    2'h0
`define PCSO_OUT_SP1_LO    2'h1
`define PCSO_OUT_SP2_HI    2'h2
`define PCSO_OUT_SP2_LO    2'h3
`define PCSO_DIAG_SYNC     0
`define PCSO_DIAG_HIT1     1
`define PCSO_DIAG_HIT2     2
`define PCSO_DIAG_OVF      3
`define PCSO_SP_RESET      16'h0000
`define PCSO_POS_RESET     16'h0000
`endif

/* hdl/pcso_pkg.sv */
// types of the setpoint-compare block
package pcso_pkg;
  typedef logic signed [15:0] pcso_word_t;
  typedef enum logic [1:0] {
    PCSO_DIR_HOLD,
    PCSO_DIR_UP,
    PCSO_DIR_DOWN
  } pcso_dir_e;
endpackage : pcso_pkg

/* hdl/pcso_sync_if.sv */
// carrier between the pin synchroniser and the compare logic
`timescale 1ns/100ps
`default_nettype none
interface pcso_sync_if;
  logic enable_level;
  logic enable_rise;
  logic enable_fall;
  modport src (output enable_level, output enable_rise, output enable_fall);
  modport dst (input enable_level, input enable_rise, input enable_fall);
endinterface : pcso_sync_if
`default_nettype wire

/* hdl/pcso_enable_sync.sv */
// three-stage synchroniser and edge detector for the enable pin
`timescale 1ns/100ps
`default_nettype none
module pcso_enable_sync (
  input  wire logic  clk_i,
  input  wire logic  rstn_i,
  input  wire logic  enable_pin_i,
  pcso_sync_if.src   sync
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       level;
  logic       next_level;

  always_comb begin
    next_stage = {stage[1:0], enable_pin_i};
    next_level = level;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign sync.enable_level = level;
  assign sync.enable_rise  = next_level & ~level;
  assign sync.enable_fall  = ~next_level & level;
endmodule : pcso_enable_sync
`default_nettype wire

/* test/pcso_setpoint_outputs_chk.sv */
// port assertions of the setpoint-compare block
`timescale 1ns/100ps
`default_nettype none
module pcso_setpoint_outputs_chk (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       enable_pin_i,
  input wire logic       sync_done_i,
  input wire logic [1:0] in_addr_i,
  input wire logic [7:0] in_data_o,
  input wire logic       first_output_o,
  input wire logic       second_output_o
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_hold_one: assert property ($fell(first_output_o) |-> !$past(enable_pin_i, 2))
    else $error("output one dropped with enable high");
  a_hold_two: assert property ($fell(second_output_o) |-> !$past(enable_pin_i, 2))
    else $error("output two dropped with enable high");
  a_rise_enable: assert property ($rose(first_output_o) |-> $past(enable_pin_i, 3))
    else $error("output one rose without enable");
  a_unused_zero: assert property (in_addr_i == 2'h0 |=> in_data_o == 8'h00)
    else $error("unused byte not zero");
  a_diag_high: assert property (in_addr_i == 2'h1 |=> in_data_o[7:4] == 4'h0)
    else $error("diagnostic upper bits set");
  a_diag_one: assert property (in_addr_i == 2'h1 |=> in_data_o[1] == $past(first_output_o))
    else $error("diagnostic bit one differs from output one");
  a_diag_two: assert property (in_addr_i == 2'h1 |=> in_data_o[2] == $past(second_output_o))
    else $error("diagnostic bit two differs from output two");
  a_sync_clear: assert property (sync_done_i ##2 in_addr_i == 2'h1 |=> in_data_o[3:0] ==? 4'b0??1)
    else $error("sync did not clear overflow");
  c_out_one: cover property ($rose(first_output_o));
  c_out_two: cover property ($fell(second_output_o));
  c_sync: cover property (sync_done_i);
endmodule : pcso_setpoint_outputs_chk
bind pcso_setpoint_outputs pcso_setpoint_outputs_chk pcso_setpoint_outputs_chk_i (.clk_i,
  .rstn_i, .enable_pin_i, .sync_done_i, .in_addr_i, .in_data_o, .first_output_o, .second_output_o);
`default_nettype wire

/* test/pcso_cpu_model.sv */
// controller model reaching the block through the process-image bytes
`timescale 1ns/100ps
`default_nettype none
module pcso_cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] in_data_i,
  output logic      [1:0] out_addr_o = 2'h0,
  output logic      [7:0] out_data_o = 8'h00,
  output logic            out_wr_o = 1'b0,
  output logic      [1:0] in_addr_o = 2'h0
);
  // ****
  // image access, adr is the image byte address of the slot
  // ****
  task automatic wr_sp(input int adr, input logic [15:0] w);
    @(posedge clk_i) #1;
    out_wr_o = 1'b1;
    out_addr_o = adr[1:0];
    out_data_o = w[15:8];
    @(posedge clk_i) #1;
    out_addr_o = adr[1:0] + 2'h1;
    out_data_o = w[7:0];
    @(posedge clk_i) #1;
    out_wr_o = 1'b0;
    out_data_o = ~w[7:0];
  endtask : wr_sp
  task automatic rd(input int adr, output logic [7:0] d);
    @(posedge clk_i) #1;
    in_addr_o = adr[1:0];
    @(posedge clk_i) #1;
    d = in_data_i;
  endtask : rd
endmodule : pcso_cpu_model
`default_nettype wire

/* test/test_pcso_setpoint_outputs.sv */
// self-checking bench of the setpoint-compare block
`timescale 1ns/100ps
`default_nettype none
module test_pcso_setpoint_outputs;
  localparam int B = 96;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       en = 1'b0;
  logic       up = 1'b0;
  logic       dn = 1'b0;
  logic       sd = 1'b0;
  logic [1:0] oa;
  logic [1:0] ia;
  logic [7:0] od;
  logic [7:0] id;
  logic       ow;
  logic       q1;
  logic       q2;
  int         errors = 0;
  int         cmp_count = 0;
  always #20 clk = ~clk;
  pcso_setpoint_outputs pcso_setpoint_outputs_i (.clk_i(clk), .rstn_i(rst_n), .enable_pin_i(en),
    .count_up_i(up), .count_down_i(dn), .sync_done_i(sd), .out_addr_i(oa), .out_data_i(od),
    .out_wr_i(ow), .in_addr_i(ia), .in_data_o(id), .first_output_o(q1), .second_output_o(q2));
  pcso_cpu_model pcso_cpu_model_i (.clk_i(clk), .in_data_i(id), .out_addr_o(oa),
    .out_data_o(od), .out_wr_o(ow), .in_addr_o(ia));
  // ****
  // helpers
  // ****
  task automatic rdc(input int a, input logic [7:0] e);
    logic [7:0] d;
    pcso_cpu_model_i.rd(a, d);
    cmp_count++;
    if (d !== e) begin
      errors++;
      $display("MISMATCH %0t byte %0d is %h not %h", $time, a, d, e);
    end
  endtask : rdc
  task automatic chk2(input logic [1:0] e);
    repeat (2) @(posedge clk);
    #1;
    cmp_count++;
    if ({q2, q1} !== e) begin
      errors++;
      $display("MISMATCH %0t outputs %b not %b", $time, {q2, q1}, e);
    end
  endtask : chk2
  task automatic cnt(input int n, input logic u);
    repeat (n) begin
      @(posedge clk) #1;
      up = u;
      dn = ~u;
      @(posedge clk) #1;
      up = 1'b0;
      dn = 1'b0;
    end
  endtask : cnt
  task automatic sen(input logic v);
    @(posedge clk) #1;
    en = v;
    repeat (6) @(posedge clk);
  endtask : sen
  task automatic syn;
    @(posedge clk) #1;
    sd = 1'b1;
    @(posedge clk) #1;
    sd = 1'b0;
  endtask : syn
  task automatic wr(input int a, input logic [15:0] w);
    pcso_cpu_model_i.wr_sp(a, w);
  endtask : wr
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // ****
  // scenarios
  // ****
  task automatic t_hits;
    rdc(B + 1, 8'h00);
    syn();
    rdc(B + 1, 8'h01);
    cnt(2, 1'b0);
    rdc(B + 2, 8'hFF);
    rdc(B + 3, 8'hFE);
    wr(B, 16'h0001);
    wr(B + 2, 16'h0003);
    sen(1'b1);
    cnt(3, 1'b1);
    chk2(2'b01);
    cnt(2, 1'b1);
    rdc(B + 1, 8'h07);
    cnt(3, 1'b0);
    chk2(2'b11);
    $display("hits done");
  endtask : t_hits
  task automatic t_pend;
    wr(B, 16'h0005);
    wr(B + 2, 16'h0007);
    sen(1'b0);
    rdc(B + 1, 8'h01);
    sen(1'b1);
    cnt(3, 1'b1);
    chk2(2'b00);
    cnt(2, 1'b1);
    chk2(2'b01);
    cnt(2, 1'b1);
    chk2(2'b11);
    $display("pending done");
  endtask : t_pend
  task automatic t_ovf;
    sen(1'b0);
    chk2(2'b00);
    wr(B, 16'h7FFF);
    wr(B + 2, 16'h8001);
    sen(1'b1);
    cnt(32760, 1'b1);
    chk2(2'b01);
    cnt(1, 1'b1);
    rdc(B + 1, 8'h0B);
    cnt(1, 1'b1);
    chk2(2'b01);
    syn();
    rdc(B + 1, 8'h03);
    rdc(B + 2, 8'h00);
    wr(B + 2, 16'h0002);
    cnt(2, 1'b1);
    chk2(2'b11);
    $display("overflow done");
  endtask : t_ovf
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_hits();
    t_pend();
    t_ovf();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : test_pcso_setpoint_outputs
`default_nettype wire
